// >>> pss_selector.v
// power source selector with axi4-lite control
// Behaviour
// R01: adapter sense comparator low means adapter lost, whatever the real supply
// R02: adapter present output follows detected adapter power, any source
// R03: adapter lost while on adapter: adapter gate high, battery gate low
// R04: adapter return: choose source from select input and presence
// R05: host drives select low to stay on battery after adapter returns
// R06: battery removed while on battery with adapter: move to adapter
// R07: manual variant pulses alarm when switches differ from commanded states
// R08: changeover waits outgoing gate off, then dead time before incoming on
// R09: host holds select low for learn cycle, high to reselect adapter
// R10: charging suspended while battery is selected source
// R11: manual variant stays on current source at depletion
// R12: auto variant moves to adapter below deep discharge level
// R13: selecting battery turns adapter path off before battery path on
// R14: battery switch on only when system voltage not above battery
// R15: grounded system sense skips system voltage check
// R16: adapter removal enters sleep, disabling system voltage check
// R17: alarm high for as long as battery depleted persists
// R18: host on manual variant picks source at depletion
// R19: adapter switch off once adapter sense below threshold
// R20: all comparator and select inputs pass two register stages
// R21: both gates off after reset until inputs evaluated once
`timescale 1ns/1ps
`include "pss_defs.vh"
module pss_selector #(
  parameter DEAD_CYC  = `PSS_DEAD_CYC,
  parameter PULSE_CYC = `PSS_ALARM_PULSE_CYC
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        nrst_i,
  // comparator and host inputs
  input  wire        adapter_sense_in_i,
  input  wire        source_select_in_i,
  input  wire        depleted_i,
  input  wire        deep_discharge_i,
  input  wire        battery_present_i,
  input  wire        sys_le_batt_i,
  input  wire        sys_sense_grounded_i,
  input  wire        adapter_gate_fb_i,
  input  wire        battery_gate_fb_i,
  // outputs
  output reg         adapter_present_out_o,
  output reg         adapter_switch_gate_n_o,
  output reg         battery_switch_gate_n_o,
  output reg         alarm_o,
  output reg         charge_enable_o,
  output reg         sleep_o,
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  wire [8:0] raw_w;
  wire [8:0] syn_w;
  assign raw_w = {battery_gate_fb_i, adapter_gate_fb_i, sys_sense_grounded_i, sys_le_batt_i,
                  battery_present_i, deep_discharge_i, depleted_i, source_select_in_i,
                  adapter_sense_in_i};
  pss_sync #(.W(9)) u_sync ( // [R20]
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    (raw_w),
    .q_o    (syn_w)
  );
  wire ac_ok     = syn_w[0]; // [R01]
  wire sel_ac    = syn_w[1];
  wire dep       = syn_w[2];
  wire deep      = syn_w[3];
  wire bat_ok    = syn_w[4];
  wire sys_le    = syn_w[5];
  wire vs_gnd    = syn_w[6];
  wire ac_fb_off = syn_w[7];
  wire bt_fb_off = syn_w[8];

  // ----------------------------------------
  // control register
  // ----------------------------------------
  reg [31:0] ctrl_reg;
  wire       auto_mode = ctrl_reg[`PSS_CTRL_AUTO_BIT];

  // ----------------------------------------
  // source decision
  // ----------------------------------------
  // want_bat: 1 battery, 0 adapter
  reg want_bat;
  reg want_none;
  always @* begin
    want_bat  = 1'b0;
    want_none = 1'b0;
    if (!ac_ok) begin
      want_bat  = 1'b1; // [R03] [R19]
      want_none = !bat_ok;
    end else if (!bat_ok) begin
      want_bat = 1'b0; // [R06]
    end else if (auto_mode && deep) begin
      want_bat = 1'b0; // [R12]
    end else begin
      want_bat = !sel_ac; // [R04] [R11]
    end
  end

  // ----------------------------------------
  // selector state machine
  // ----------------------------------------
  reg [2:0]  st_reg;
  reg        tgt_bat_reg;
  reg [7:0]  cnt_reg;
  reg        init_done_reg;
  wire       sleep_w  = !ac_ok; // [R16]
  wire       vs_ok    = sys_le || vs_gnd || sleep_w; // [R14] [R15] [R16]
  wire       on_bat   = (st_reg == `PSS_ST_BATTERY);
  wire       on_ac    = (st_reg == `PSS_ST_ADAPTER);
  wire       busy     = (st_reg == `PSS_ST_DEAD);
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg        <= `PSS_ST_INIT;
      tgt_bat_reg   <= 1'b0;
      cnt_reg       <= 8'h00;
      init_done_reg <= 1'b0;
    end else begin
      case (st_reg)
        `PSS_ST_INIT: begin
          init_done_reg <= 1'b1;
          if (init_done_reg) begin // [R21]
            st_reg <= `PSS_ST_OFF;
          end
        end
        `PSS_ST_OFF: begin
          if (!want_none && ac_fb_off && bt_fb_off) begin // [R08]
            tgt_bat_reg <= want_bat;
            cnt_reg     <= 8'h00;
            st_reg      <= `PSS_ST_DEAD;
          end
        end
        `PSS_ST_DEAD: begin
          if (want_none || want_bat != tgt_bat_reg) begin
            st_reg <= `PSS_ST_OFF;
          end else if (cnt_reg >= DEAD_CYC[7:0] - 8'h01) begin // [R08]
            if (!tgt_bat_reg) begin
              st_reg <= `PSS_ST_ADAPTER;
            end else if (vs_ok) begin // [R13] [R14]
              st_reg <= `PSS_ST_BATTERY;
            end
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        `PSS_ST_ADAPTER: begin
          if (want_none || want_bat) begin
            st_reg <= `PSS_ST_OFF; // [R13] [R19]
          end
        end
        `PSS_ST_BATTERY: begin
          if (want_none || !want_bat) begin
            st_reg <= `PSS_ST_OFF;
          end
        end
        default: begin
          st_reg <= `PSS_ST_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------
  // fault alarm pulse
  // ----------------------------------------
  localparam SETTLE_CYC = `PSS_FB_SETTLE_CYC;
  reg [7:0] pulse_reg;
  reg [7:0] settle_reg;
  // feedback lags the gates, so judge only a settled source
  wire      settled  = (settle_reg == SETTLE_CYC[7:0]);
  wire      mismatch = settled && ((on_ac && (ac_fb_off || !bt_fb_off)) ||
                       (on_bat && (bt_fb_off || !ac_fb_off)));
  reg       mism_d_reg;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pulse_reg  <= 8'h00;
      settle_reg <= 8'h00;
      mism_d_reg <= 1'b0;
    end else begin
      mism_d_reg <= mismatch;
      if (!on_ac && !on_bat) begin
        settle_reg <= 8'h00;
      end else if (!settled) begin
        settle_reg <= settle_reg + 8'h01;
      end
      if (!auto_mode && mismatch && !mism_d_reg) begin
        pulse_reg <= PULSE_CYC[7:0]; // [R07]
      end else if (pulse_reg != 8'h00) begin
        pulse_reg <= pulse_reg - 8'h01;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      adapter_present_out_o   <= 1'b0;
      adapter_switch_gate_n_o <= 1'b1;
      battery_switch_gate_n_o <= 1'b1;
      alarm_o                 <= 1'b0;
      charge_enable_o         <= 1'b0;
      sleep_o                 <= 1'b0;
    end else begin
      adapter_present_out_o   <= ac_ok; // [R02]
      adapter_switch_gate_n_o <= !(on_ac && ac_ok && !want_bat); // [R03] [R19]
      battery_switch_gate_n_o <= !(on_bat && want_bat && !want_none); // [R06] [R13]
      alarm_o                 <= dep || (pulse_reg != 8'h00); // [R17] [R07]
      charge_enable_o         <= on_ac && ac_ok; // [R10]
      sleep_o                 <= sleep_w; // [R16]
    end
  end

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  reg [7:0]  awaddr_reg;
  reg        aw_have_reg;
  reg [31:0] wdata_reg;
  reg [3:0]  wstrb_reg;
  reg        w_have_reg;
  wire [31:0] stat_w = {24'h000000, busy, sleep_o, alarm_o, charge_enable_o,
                        !battery_switch_gate_n_o, !adapter_switch_gate_n_o,
                        adapter_present_out_o, on_bat};
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
      ctrl_reg      <= `PSS_CTRL_RESET;
    end else begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_have_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg   <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_reg[7:2] == `PSS_OFF_CTRL >> 2) begin
          s_axi_bresp <= 2'b00;
          if (wstrb_reg[0]) begin
            ctrl_reg[7:0] <= {7'h00, wdata_reg[0]};
          end
        end else if (awaddr_reg[7:2] == `PSS_OFF_STAT >> 2) begin
          s_axi_bresp <= 2'b00;
        end else begin
          s_axi_bresp <= 2'b10;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        if (s_axi_araddr[7:2] == `PSS_OFF_CTRL >> 2) begin
          s_axi_rdata <= ctrl_reg;
          s_axi_rresp <= 2'b00;
        end else if (s_axi_araddr[7:2] == `PSS_OFF_STAT >> 2) begin
          s_axi_rdata <= stat_w;
          s_axi_rresp <= 2'b00;
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'b10;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // pss_selector

// >>> pss_defs.vh
// constants for the power source selector
`ifndef PSS_DEFS_VH
`define PSS_DEFS_VH
// ----------------------------------------
// timing
// ----------------------------------------
`define PSS_CLK_MHZ        40
`define PSS_DEAD_NS        150
`define PSS_DEAD_CYC       ((`PSS_DEAD_NS * `PSS_CLK_MHZ + 999) / 1000)
`define PSS_ALARM_PULSE_CYC 8
`define PSS_FB_SETTLE_CYC  16
// ----------------------------------------
// register map
// ----------------------------------------
`define PSS_OFF_CTRL       8'h00
`define PSS_OFF_STAT       8'h04
`define PSS_CTRL_AUTO_BIT  0
`define PSS_CTRL_RESET     32'h00000000
// ----------------------------------------
// selector states
// ----------------------------------------
`define PSS_ST_INIT        3'h0
`define PSS_ST_OFF         3'h1
`define PSS_ST_ADAPTER     3'h2
`define PSS_ST_BATTERY     3'h3
`define PSS_ST_DEAD        3'h4
`endif

// >>> pss_sync.v
// two-stage synchroniser bank
`timescale 1ns/1ps
module pss_sync #(
  parameter W = 6
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         nrst_i,
  // data
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
    end
  end
  assign q_o = s2_reg;
endmodule // pss_sync

// >>> pss_switch_model.sv
// switch gate feedback model for the selector
`timescale 1ns/1ps
module pss_switch_model (
  // clock
  input  wire clk_i,
  // gate drives and control
  input  wire adapter_gate_n_i,
  input  wire battery_gate_n_i,
  input  wire slow_i,
  input  wire fault_i,
  // measured gate levels
  output wire adapter_gate_fb_o,
  output wire battery_gate_fb_o
);
  // ----
  // gate level lag
  // ----
  reg [7:0] hist_reg;
  always @(posedge clk_i) begin
    hist_reg <= {hist_reg[5:0], adapter_gate_n_i, battery_gate_n_i};
  end
  // fault shows an on switch as off
  assign adapter_gate_fb_o = (slow_i ? hist_reg[7] : hist_reg[1]) | fault_i;
  assign battery_gate_fb_o = (slow_i ? hist_reg[6] : hist_reg[0]) | fault_i;
endmodule // pss_switch_model

// >>> pss_selector_properties.sv
// assertions on selector ports
`timescale 1ns/1ps
module pss_selector_properties #(
  parameter DEAD_CYC = 6
) (
  // clock and reset
  input wire clk_i,
  input wire nrst_i,
  // watched inputs
  input wire adapter_sense_in_i,
  input wire depleted_i,
  input wire sys_le_batt_i,
  input wire sys_sense_grounded_i,
  // watched outputs
  input wire adapter_present_out_o,
  input wire adapter_switch_gate_n_o,
  input wire battery_switch_gate_n_o,
  input wire alarm_o,
  input wire charge_enable_o,
  input wire sleep_o
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  chk_present_up: assert property (adapter_sense_in_i [*6] |-> adapter_present_out_o)
    else $error("present not raised");
  chk_present_down: assert property (!adapter_sense_in_i [*6] |-> !adapter_present_out_o)
    else $error("present not cleared");
  chk_adapter_off: assert property (!adapter_sense_in_i [*6] |-> adapter_switch_gate_n_o)
    else $error("adapter gate left on");
  chk_no_overlap: assert property (adapter_switch_gate_n_o || battery_switch_gate_n_o)
    else $error("both gates on");
  chk_dead_time: assert property ($fell(battery_switch_gate_n_o) |->
    $past(adapter_switch_gate_n_o, DEAD_CYC)) else $error("dead time short");
  chk_charge_off: assert property (!battery_switch_gate_n_o |-> !charge_enable_o)
    else $error("charging on battery");
  chk_batt_safe: assert property ($fell(battery_switch_gate_n_o) |-> $past(sleep_o, 1) ||
    $past(sys_le_batt_i || sys_sense_grounded_i, 4)) else $error("battery on unsafe");
  chk_alarm_level: assert property (depleted_i [*6] |-> alarm_o)
    else $error("alarm low while depleted");
  chk_reset_gates: assert property ($rose(nrst_i) |->
    (adapter_switch_gate_n_o && battery_switch_gate_n_o) [*3]) else $error("gate on at reset");
  chk_sync_delay: assert property ($rose(adapter_sense_in_i) && !adapter_present_out_o
    |=> !adapter_present_out_o) else $error("sense not synchronised");
  cover property (!battery_switch_gate_n_o && sleep_o);
  cover property (alarm_o && !depleted_i);
  cover property ($fell(adapter_switch_gate_n_o));
endmodule // pss_selector_properties

bind pss_selector pss_selector_properties #(.DEAD_CYC(DEAD_CYC)) u_pss_selector_properties (
  .clk_i, .nrst_i, .adapter_sense_in_i, .depleted_i, .sys_le_batt_i, .sys_sense_grounded_i,
  .adapter_present_out_o, .adapter_switch_gate_n_o, .battery_switch_gate_n_o, .alarm_o,
  .charge_enable_o, .sleep_o
);

// >>> tb_pss_selector.sv
// self-checking bench for the power source selector
`timescale 1ns/1ps
`include "pss_defs.vh"
module tb_pss_selector;
  // ----
  // signals
  // ----
  reg         clk_i;
  reg         nrst_i;
  reg  [6:0]  in_reg;
  reg         slow_reg;
  reg         fault_reg;
  reg  [7:0]  s_axi_awaddr;
  reg  [7:0]  s_axi_araddr;
  reg  [31:0] s_axi_wdata;
  reg  [3:0]  s_axi_wstrb;
  reg         s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        ac_fb, bt_fb, adapter_present_out_o, adapter_switch_gate_n_o;
  wire        battery_switch_gate_n_o, alarm_o, charge_enable_o, sleep_o;
  integer     failures, checks;

  pss_selector u_pss_selector (
    .clk_i, .nrst_i, .adapter_sense_in_i(in_reg[6]), .source_select_in_i(in_reg[5]),
    .depleted_i(in_reg[4]), .deep_discharge_i(in_reg[3]), .battery_present_i(in_reg[2]),
    .sys_le_batt_i(in_reg[1]), .sys_sense_grounded_i(in_reg[0]),
    .adapter_gate_fb_i(ac_fb), .battery_gate_fb_i(bt_fb), .adapter_present_out_o,
    .adapter_switch_gate_n_o, .battery_switch_gate_n_o, .alarm_o, .charge_enable_o, .sleep_o,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  pss_switch_model u_pss_switch_model (
    .clk_i, .adapter_gate_n_i(adapter_switch_gate_n_o), .battery_gate_n_i(battery_switch_gate_n_o),
    .slow_i(slow_reg), .fault_i(fault_reg), .adapter_gate_fb_o(ac_fb), .battery_gate_fb_o(bt_fb)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // ----
  // tasks
  // ----
  task print_verdict;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task gates(input a, input b);
    begin
      chk(adapter_switch_gate_n_o, a);
      chk(battery_switch_gate_n_o, b);
    end
  endtask
  task drive(input [6:0] v, input integer n);
    begin
      in_reg <= v;
      repeat (n) @(posedge clk_i);
    end
  endtask
  task axi_wr(input [7:0] a, input [31:0] d, input [1:0] r);
    integer n;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n <= 50; n = n + 1) begin
        @(posedge clk_i);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) break;
      end
      chk(s_axi_bresp, r);
      if (n > 50) begin
        failures = failures + 1;
        $display("[FAIL] %0t write timeout", $time);
        print_verdict;
      end
    end
  endtask
  task axi_rd(input [7:0] a, input [31:0] d, input [1:0] r);
    integer n;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (n = 0; n <= 50; n = n + 1) begin
        @(posedge clk_i);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) break;
      end
      chk(s_axi_rdata, d);
      chk(s_axi_rresp, r);
      if (n > 50) begin
        failures = failures + 1;
        $display("[FAIL] %0t read timeout", $time);
        print_verdict;
      end
    end
  endtask
  // ----
  // sequence
  // ----
  initial begin
    failures = 0;
    checks = 0;
    nrst_i = 1'b0;
    in_reg = 7'h00;
    {slow_reg, fault_reg, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3f;
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    gates(1, 1);
    axi_rd(`PSS_OFF_CTRL, 32'h0, 2'h0);
    axi_rd(8'h10, 32'h0, 2'h2);
    axi_wr(8'h10, 32'h1, 2'h2);
    axi_wr(`PSS_OFF_STAT, 32'hff, 2'h0);
    drive(7'h66, 30);
    gates(0, 1);
    chk(charge_enable_o, 1);
    axi_rd(`PSS_OFF_STAT, 32'h16, 2'h0);
    slow_reg <= 1'b1;
    drive(7'h46, 40);
    gates(1, 0);
    chk(charge_enable_o, 0);
    slow_reg <= 1'b0;
    drive(7'h64, 30);
    gates(0, 1);
    drive(7'h44, 30);
    chk(battery_switch_gate_n_o, 1);
    drive(7'h45, 30);
    gates(1, 0);
    drive(7'h66, 30);
    drive(7'h24, 30);
    gates(1, 0);
    chk(adapter_present_out_o, 0);
    chk(sleep_o, 1);
    drive(7'h64, 30);
    gates(0, 1);
    chk(adapter_present_out_o, 1);
    drive(7'h46, 30);
    gates(1, 0);
    drive(7'h42, 30);
    gates(0, 1);
    drive(7'h56, 30);
    chk(alarm_o, 1);
    drive(7'h5e, 30);
    gates(1, 0);
    drive(7'h7e, 30);
    gates(0, 1);
    drive(7'h5e, 30);
    gates(1, 0);
    axi_wr(`PSS_OFF_CTRL, 32'h1, 2'h0);
    axi_rd(`PSS_OFF_CTRL, 32'h1, 2'h0);
    repeat (30) @(posedge clk_i);
    gates(0, 1);
    chk(alarm_o, 1);
    axi_wr(`PSS_OFF_CTRL, 32'h0, 2'h0);
    drive(7'h66, 30);
    chk(alarm_o, 0);
    fault_reg <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk(alarm_o, 1);
    repeat (20) @(posedge clk_i);
    chk(alarm_o, 0);
    print_verdict;
  end
endmodule // tb_pss_selector
